/* src/lcdip_regs.svh */
// Index codes, field positions and reset values of the LCD register port
`ifndef LCDIP_REGS_SVH
`define LCDIP_REGS_SVH

`define LCDIP_DATA_W       8
`define LCDIP_IDX_W        4
`define LCDIP_SLOTS        10

`define LCDIP_CODE_CTRL1   4'h0
`define LCDIP_CODE_CTRL2   4'h1
`define LCDIP_CODE_ADDR    4'h2
`define LCDIP_CODE_FRAME   4'h3
`define LCDIP_CODE_PIXEL   4'h4
`define LCDIP_CODE_START   4'h5
`define LCDIP_CODE_BLINK   4'h6
`define LCDIP_CODE_BSTART  4'h8
`define LCDIP_CODE_BEND    4'h9
`define LCDIP_CODE_CONTR   4'hA

`define LCDIP_SLOT_CTRL1   0
`define LCDIP_SLOT_CTRL2   1
`define LCDIP_SLOT_ADDR    2
`define LCDIP_SLOT_FRAME   3
`define LCDIP_SLOT_PIXEL   4
`define LCDIP_SLOT_START   5
`define LCDIP_SLOT_BLINK   6
`define LCDIP_SLOT_BSTART  7
`define LCDIP_SLOT_BEND    8
`define LCDIP_SLOT_CONTR   9

`define LCDIP_C1_STBY      5
`define LCDIP_C1_BOOST     4
`define LCDIP_C1_GRAPH     2
`define LCDIP_C1_DUTY_HI   1
`define LCDIP_C1_DUTY_LO   0

`define LCDIP_C2_PANEL     6
`define LCDIP_C2_OPAMP     4
`define LCDIP_C2_RMW       3
`define LCDIP_C2_INC       1
`define LCDIP_C2_BLINK     0

`define LCDIP_IDX_RESET    4'h0
`define LCDIP_CTRL1_RESET  8'h00
`define LCDIP_BYTE_ZERO    8'h00
`define LCDIP_SEG_CHAR     8'h1F
`define LCDIP_SEG_GRAPH    8'hFF

`endif

/* src/lcdip_pkg.sv */
// Types shared by the LCD register port modules
package lcdip_pkg;
	typedef enum logic [1:0] {
		LCDIP_DUTY_32,
		LCDIP_DUTY_16,
		LCDIP_DUTY_8
	} lcdip_duty_t;
endpackage

/* src/lcdip_wr_if.sv */
// Write path between the port front end, the index decoder and control one
`timescale 1ns/1ps
`default_nettype none
`include "lcdip_regs.svh"

interface lcdip_wr_if;
	logic [`LCDIP_IDX_W-1:0]  index;
	logic [`LCDIP_SLOTS-1:0]  sel;
	logic                     hit;
	logic                     ctrl1_wr;
	logic [`LCDIP_DATA_W-1:0] data;
	logic                     standby_set;

	modport dec (input index, output sel, output hit);
	modport ctl (input ctrl1_wr, input data, output standby_set);
	modport front (output index, input sel, input hit, output ctrl1_wr, output data,
		input standby_set);
endinterface

`default_nettype wire

/* src/lcdip_index_decoder.sv */
// Maps the four-bit index code onto one of ten register slots
`timescale 1ns/1ps
`default_nettype none
`include "lcdip_regs.svh"

module lcdip_index_decoder (
	lcdip_wr_if.dec bus
);
	import lcdip_pkg::*;

	always_comb begin
		bus.sel = '0;
		case (bus.index)
			`LCDIP_CODE_CTRL1:  bus.sel[`LCDIP_SLOT_CTRL1] = 1'b1;
			`LCDIP_CODE_CTRL2:  bus.sel[`LCDIP_SLOT_CTRL2] = 1'b1;
			`LCDIP_CODE_ADDR:   bus.sel[`LCDIP_SLOT_ADDR] = 1'b1;
			`LCDIP_CODE_FRAME:  bus.sel[`LCDIP_SLOT_FRAME] = 1'b1;
			`LCDIP_CODE_PIXEL:  bus.sel[`LCDIP_SLOT_PIXEL] = 1'b1;
			`LCDIP_CODE_START:  bus.sel[`LCDIP_SLOT_START] = 1'b1;
			`LCDIP_CODE_BLINK:  bus.sel[`LCDIP_SLOT_BLINK] = 1'b1;
			`LCDIP_CODE_BSTART: bus.sel[`LCDIP_SLOT_BSTART] = 1'b1;
			`LCDIP_CODE_BEND:   bus.sel[`LCDIP_SLOT_BEND] = 1'b1;
			`LCDIP_CODE_CONTR:  bus.sel[`LCDIP_SLOT_CONTR] = 1'b1;
			// Codes 7 and B to F select nothing
			default:            bus.sel = '0;
		endcase
	end

	assign bus.hit = |bus.sel;
endmodule

`default_nettype wire

/* src/lcdip_ctrl_one.sv */
// Control register one and the controls derived from it
`timescale 1ns/1ps
`default_nettype none
`include "lcdip_regs.svh"

module lcdip_ctrl_one (
	input  wire logic                     sys_clk,
	input  wire logic                     rst_n,
	input  wire logic                     clk_en,
	lcdip_wr_if.ctl                       bus,
	output logic                          standby_q,
	output logic                          boost_enable_q,
	output logic                          boost_run_q,
	output logic                          graphic_mode_q,
	output logic [1:0]                    duty_code_q,
	output lcdip_pkg::lcdip_duty_t        duty_sel_q,
	output logic [`LCDIP_DATA_W-1:0]      seg_mask_q,
	output logic                          scan_run_q
);
	import lcdip_pkg::*;

	logic                  wr_stby;
	logic                  wr_boost;
	logic                  wr_graph;
	logic [1:0]            wr_duty;
	lcdip_duty_t           duty_d;

	// Named copy so single fields can be selected; a literal cannot be indexed
	localparam logic [`LCDIP_DATA_W-1:0] ctrl1_reset = `LCDIP_CTRL1_RESET;

	assign wr_stby  = bus.data[`LCDIP_C1_STBY];
	assign wr_boost = bus.data[`LCDIP_C1_BOOST];
	assign wr_graph = bus.data[`LCDIP_C1_GRAPH];
	assign wr_duty  = bus.data[`LCDIP_C1_DUTY_HI:`LCDIP_C1_DUTY_LO];

	always_comb begin
		if (wr_duty[1]) begin
			duty_d = LCDIP_DUTY_8;
		end else if (wr_duty[0]) begin
			duty_d = LCDIP_DUTY_16;
		end else begin
			duty_d = LCDIP_DUTY_32;
		end
	end

	// Stored fields; bits 7, 6 and 3 are not kept
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			standby_q      <= ctrl1_reset[`LCDIP_C1_STBY];
			boost_enable_q <= ctrl1_reset[`LCDIP_C1_BOOST];
			graphic_mode_q <= ctrl1_reset[`LCDIP_C1_GRAPH];
			duty_code_q    <= ctrl1_reset[`LCDIP_C1_DUTY_HI:`LCDIP_C1_DUTY_LO];
		end else if (clk_en && bus.ctrl1_wr) begin
			standby_q      <= wr_stby;
			boost_enable_q <= wr_boost;
			graphic_mode_q <= wr_graph;
			duty_code_q    <= wr_duty;
		end
	end

	// Derived controls follow the same write so they never lag the fields
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			boost_run_q <= 1'b0;
			scan_run_q  <= 1'b1;
			seg_mask_q  <= `LCDIP_SEG_CHAR;
			duty_sel_q  <= LCDIP_DUTY_32;
		end else if (clk_en && bus.ctrl1_wr) begin
			boost_run_q <= wr_boost & ~wr_stby;
			scan_run_q  <= ~wr_stby;
			seg_mask_q  <= wr_graph ? `LCDIP_SEG_GRAPH : `LCDIP_SEG_CHAR;
			duty_sel_q  <= duty_d;
		end
	end

	assign bus.standby_set = bus.ctrl1_wr & wr_stby;
endmodule

`default_nettype wire

/* src/lcdip_port.sv */
// Index and control register port of the dot-matrix LCD controller
`timescale 1ns/1ps
`default_nettype none
`include "lcdip_regs.svh"

module lcdip_port (
	input  wire logic                     sys_clk,
	input  wire logic                     rst_n,
	input  wire logic                     clk_en,
	input  wire logic                     reg_select_line,
	input  wire logic                     wr_strobe,
	input  wire logic                     rd_strobe,
	input  wire logic [7:0]               host_wdata,
	input  wire logic [7:0]               pixel_rd_data,
	output logic [7:0]                    host_rdata_q,
	output logic                          host_rvalid_q,
	output logic                          pixel_rd_pulse_q,
	output logic [3:0]                    index_code_field_q,
	output logic                          index_valid_q,
	output logic [9:0]                    slot_wr_pulse_q,
	output logic [7:0]                    slot_wdata_q,
	output logic                          module_standby_bit,
	output logic                          boost_enable,
	output logic                          boost_run,
	output logic                          graphic_mode_select,
	output logic [1:0]                    duty_code,
	output var lcdip_pkg::lcdip_duty_t    duty_sel,
	output logic [7:0]                    seg_mask,
	output logic                          scan_run,
	output logic                          panel_on_q,
	output logic                          opamp_enable_q,
	output logic                          rmw_mode_q,
	output logic                          inc_x_first_q,
	output logic                          blink_enable_q,
	output logic                          blink_active_q,
	output logic                          lcd_ground_q
);
	import lcdip_pkg::*;

	lcdip_wr_if wr_bus ();

	logic                         wr_take;
	logic                         rd_take;
	logic                         idx_wr;
	logic                         slot_wr;
	logic                         ctrl2_wr;
	logic                         pixel_rd;
	logic                         panel_on_d;
	logic                         opamp_d;
	logic                         blink_d;
	logic                         standby_w;
	logic                         boost_en_w;
	logic                         boost_run_w;
	logic                         graph_w;
	logic [1:0]                   duty_code_w;
	lcdip_duty_t                  duty_sel_w;
	logic [`LCDIP_DATA_W-1:0]     seg_mask_w;
	logic                         scan_run_w;

	// Strobes are sampled only on enabled edges
	assign wr_take = wr_strobe & clk_en;
	assign rd_take = rd_strobe & clk_en;

	assign idx_wr   = wr_take & ~reg_select_line;
	assign slot_wr  = wr_take & reg_select_line & wr_bus.hit;
	assign ctrl2_wr = slot_wr & wr_bus.sel[`LCDIP_SLOT_CTRL2];
	assign pixel_rd = rd_take & reg_select_line & wr_bus.sel[`LCDIP_SLOT_PIXEL];

	assign wr_bus.index    = index_code_field_q;
	assign wr_bus.data     = host_wdata;
	assign wr_bus.ctrl1_wr = slot_wr & wr_bus.sel[`LCDIP_SLOT_CTRL1];

	lcdip_index_decoder u_dec (
		.bus (wr_bus.dec)
	);

	lcdip_ctrl_one u_ctrl1 (
		.sys_clk        (sys_clk),
		.rst_n          (rst_n),
		.clk_en         (clk_en),
		.bus            (wr_bus.ctl),
		.standby_q      (standby_w),
		.boost_enable_q (boost_en_w),
		.boost_run_q    (boost_run_w),
		.graphic_mode_q (graph_w),
		.duty_code_q    (duty_code_w),
		.duty_sel_q     (duty_sel_w),
		.seg_mask_q     (seg_mask_w),
		.scan_run_q     (scan_run_w)
	);

	// Control one fields leave the submodule straight from its flops
	assign module_standby_bit  = standby_w;
	assign boost_enable        = boost_en_w;
	assign boost_run           = boost_run_w;
	assign graphic_mode_select = graph_w;
	assign duty_code           = duty_code_w;
	assign duty_sel            = duty_sel_w;
	assign seg_mask            = seg_mask_w;
	assign scan_run            = scan_run_w;

	// Index register; reserved upper bits are not stored
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			index_code_field_q <= `LCDIP_IDX_RESET;
		end else if (idx_wr) begin
			index_code_field_q <= host_wdata[`LCDIP_IDX_W-1:0];
		end
	end

	// Index validity flag shown for status, tracks the stored code
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			index_valid_q <= 1'b1;
		end else if (clk_en) begin
			index_valid_q <= wr_bus.hit;
		end
	end

	// One-cycle write pulses toward the registers held elsewhere
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			slot_wr_pulse_q <= '0;
			slot_wdata_q    <= `LCDIP_BYTE_ZERO;
		end else if (clk_en) begin
			slot_wr_pulse_q <= slot_wr ? wr_bus.sel : '0;
			if (slot_wr) begin
				slot_wdata_q <= host_wdata;
			end
		end
	end

	// Control two next values; a standby write blanks panel and op-amps
	always_comb begin
		panel_on_d = panel_on_q;
		opamp_d    = opamp_enable_q;
		if (wr_bus.standby_set && slot_wr) begin
			panel_on_d = 1'b0;
			opamp_d    = 1'b0;
		end else if (ctrl2_wr) begin
			// Standby keeps the panel dark even if software sets the bit
			panel_on_d = host_wdata[`LCDIP_C2_PANEL] & ~standby_w;
			opamp_d    = host_wdata[`LCDIP_C2_OPAMP] & ~standby_w;
		end
	end

	assign blink_d = ctrl2_wr ? host_wdata[`LCDIP_C2_BLINK] : blink_enable_q;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			panel_on_q     <= 1'b0;
			opamp_enable_q <= 1'b0;
			rmw_mode_q     <= 1'b0;
			inc_x_first_q  <= 1'b0;
			blink_enable_q <= 1'b0;
		end else if (clk_en) begin
			panel_on_q     <= panel_on_d;
			opamp_enable_q <= opamp_d;
			blink_enable_q <= blink_d;
			if (ctrl2_wr) begin
				rmw_mode_q    <= host_wdata[`LCDIP_C2_RMW];
				inc_x_first_q <= host_wdata[`LCDIP_C2_INC];
			end
		end
	end

	// Panel outputs follow the same edge as the panel bit itself
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			lcd_ground_q   <= 1'b1;
			blink_active_q <= 1'b0;
		end else if (clk_en) begin
			lcd_ground_q   <= ~panel_on_d;
			blink_active_q <= blink_d & panel_on_d;
		end
	end

	// Host read path; only the display data slot answers with data
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			host_rdata_q     <= `LCDIP_BYTE_ZERO;
			host_rvalid_q    <= 1'b0;
			pixel_rd_pulse_q <= 1'b0;
		end else if (clk_en) begin
			host_rvalid_q    <= rd_take;
			pixel_rd_pulse_q <= pixel_rd;
			if (rd_take) begin
				host_rdata_q <= pixel_rd ? pixel_rd_data : `LCDIP_BYTE_ZERO;
			end
		end
	end
endmodule

`default_nettype wire

/* test/lcdip_port_properties.sv */
// Concurrent checks on the pins of the LCD register port
`timescale 1ns/1ps
`default_nettype none
module lcdip_port_props (
	input wire logic       sys_clk,
	input wire logic       rst_n,
	input wire logic       clk_en,
	input wire logic       reg_select_line,
	input wire logic       wr_strobe,
	input wire logic       rd_strobe,
	input wire logic [7:0] host_wdata,
	input wire logic [7:0] host_rdata_q,
	input wire logic       host_rvalid_q,
	input wire logic [3:0] index_code_field_q,
	input wire logic [9:0] slot_wr_pulse_q,
	input wire logic       module_standby_bit,
	input wire logic       boost_enable,
	input wire logic       boost_run,
	input wire logic       scan_run,
	input wire logic       panel_on_q,
	input wire logic       opamp_enable_q,
	input wire logic       lcd_ground_q
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	logic wr_idx;
	logic wr_slot;
	assign wr_idx = clk_en && wr_strobe && !reg_select_line;
	assign wr_slot = clk_en && wr_strobe && reg_select_line;
	index_load_a: assert property (wr_idx |=> index_code_field_q == $past(host_wdata[3:0]))
		else $error("index register not loaded");
	ctrl_route_a: assert property (wr_slot && index_code_field_q == 4'h0 |=> slot_wr_pulse_q == 10'h001)
		else $error("control one write not routed");
	bad_code_a: assert property (wr_slot && (index_code_field_q == 4'h7 || index_code_field_q > 4'hA)
		|=> slot_wr_pulse_q == 10'h000)
		else $error("invalid index code took a write");
	wo_read_a: assert property (clk_en && rd_strobe && index_code_field_q != 4'h4
		|=> host_rvalid_q && host_rdata_q == 8'h00)
		else $error("write-only slot returned data");
	ctrl_fields_a: assert property (wr_slot && index_code_field_q == 4'h0
		|=> module_standby_bit == $past(host_wdata[5]) && boost_enable == $past(host_wdata[4]))
		else $error("control one fields misplaced");
	standby_halt_a: assert property (module_standby_bit |-> !scan_run && !boost_run)
		else $error("standby left circuits running");
	standby_clear_a: assert property ($rose(module_standby_bit) |-> !panel_on_q && !opamp_enable_q)
		else $error("standby kept panel or op-amp on");
	panel_ground_a: assert property (lcd_ground_q == !panel_on_q)
		else $error("ground level disagrees with panel on");
	cover property (wr_idx);
	cover property (wr_slot && index_code_field_q == 4'h0);
	cover property (clk_en && rd_strobe && index_code_field_q == 4'h4);
endmodule
bind lcdip_port lcdip_port_props lcdip_port_props_i (.sys_clk, .rst_n, .clk_en, .reg_select_line,
	.wr_strobe, .rd_strobe, .host_wdata, .host_rdata_q, .host_rvalid_q, .index_code_field_q,
	.slot_wr_pulse_q, .module_standby_bit, .boost_enable, .boost_run, .scan_run, .panel_on_q,
	.opamp_enable_q, .lcd_ground_q);
`default_nettype wire

/* test/lcdip_host_model.sv */
// Host processor driving the port lines of the LCD register port
`timescale 1ns/1ps
`default_nettype none
module lcdip_host_model (
	input  wire logic       sys_clk,
	output logic            reg_select_line,
	output logic            wr_strobe,
	output logic            rd_strobe,
	output logic [7:0]      host_wdata
);
	initial begin
		reg_select_line = 1'b0;
		wr_strobe = 1'b0;
		rd_strobe = 1'b0;
		host_wdata = 8'h00;
	end
	// One access per call; lines held over the taking edge
	task automatic xfer(input logic rs, input logic wr, input logic rd, input logic [7:0] d);
		@(posedge sys_clk);
		reg_select_line <= rs;
		wr_strobe <= wr;
		rd_strobe <= rd;
		host_wdata <= rs ? d : {4'h0, d[3:0]};
		@(posedge sys_clk);
		wr_strobe <= 1'b0;
		rd_strobe <= 1'b0;
		// Released port lines must not keep the last byte
		host_wdata <= ~host_wdata;
	endtask
endmodule
`default_nettype wire

/* test/lcdip_port_bench.sv */
// Self-checking bench for the LCD register port
`timescale 1ns/1ps
`default_nettype none
module lcdip_port_bench;
	import lcdip_pkg::*;
	typedef struct {logic [7:0] d; logic [15:0] e;} lcdip_row_t;
	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        clk_en = 1'b1;
	logic [7:0]  pix = 8'h00;
	logic        rs, wr, rd, rvalid, stby, boost, brun, graph, scan, panel, opamp, ground, ivalid;
	logic [7:0]  wd, rdata, mask, wdat;
	logic        pxp, rmw, inc, ben, bact;
	logic [1:0]  dcode;
	logic [3:0]  idx;
	logic [9:0]  pulse;
	lcdip_duty_t duty;
	int          n_mismatch = 0;
	int          checks_done = 0;
	int          cycles = 0;
	lcdip_row_t  rows[6];
	logic [3:0]  codes[10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA};
	always #12.5 sys_clk = ~sys_clk;
	lcdip_host_model lcdip_host_model_i (.sys_clk(sys_clk), .reg_select_line(rs),
		.wr_strobe(wr), .rd_strobe(rd), .host_wdata(wd));
	lcdip_port lcdip_port_i (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
		.reg_select_line(rs), .wr_strobe(wr), .rd_strobe(rd), .host_wdata(wd),
		.pixel_rd_data(pix), .host_rdata_q(rdata), .host_rvalid_q(rvalid), .pixel_rd_pulse_q(pxp),
		.index_code_field_q(idx), .index_valid_q(ivalid), .slot_wr_pulse_q(pulse),
		.slot_wdata_q(wdat), .module_standby_bit(stby), .boost_enable(boost), .boost_run(brun),
		.graphic_mode_select(graph), .duty_code(dcode), .duty_sel(duty), .seg_mask(mask),
		.scan_run(scan), .panel_on_q(panel), .opamp_enable_q(opamp), .rmw_mode_q(rmw),
		.inc_x_first_q(inc), .blink_enable_q(ben), .blink_active_q(bact), .lcd_ground_q(ground));
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic put(input logic rs_v, input logic rd_v, input logic [7:0] d);
		lcdip_host_model_i.xfer(rs_v, !rd_v, rd_v, d);
		@(negedge sys_clk);
	endtask
	task automatic summarize;
		if (n_mismatch == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	function automatic logic [15:0] ctl1;
		return {2'b00, stby, boost, brun, scan, mask, 2'(duty)};
	endfunction
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_mismatch++;
			summarize();
		end
	end
	initial begin
		// Standby, boost, boost run, scan, segment mask, duty
		rows[0] = '{8'h00, {6'b000001, 8'h1F, 2'(LCDIP_DUTY_32)}};
		rows[1] = '{8'h15, {6'b000111, 8'hFF, 2'(LCDIP_DUTY_16)}};
		rows[2] = '{8'h12, {6'b000111, 8'h1F, 2'(LCDIP_DUTY_8)}};
		rows[3] = '{8'h07, {6'b000001, 8'hFF, 2'(LCDIP_DUTY_8)}};
		rows[4] = '{8'h30, {6'b001100, 8'h1F, 2'(LCDIP_DUTY_32)}};
		rows[5] = '{8'h35, {6'b001100, 8'hFF, 2'(LCDIP_DUTY_16)}};
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(negedge sys_clk);
		chk("index", 16'h0010, {11'h000, ivalid, idx});
		chk("ctrl1", rows[0].e, ctl1());
		put(1'b0, 1'b0, 8'h00);
		foreach (rows[i]) begin
			put(1'b1, 1'b0, rows[i].d);
			chk("ctrl1", rows[i].e, ctl1());
		end
		chk("duty", 16'h0005, {13'h0000, graph, dcode});
		foreach (codes[i]) begin
			put(1'b0, 1'b0, {4'h0, codes[i]});
			put(1'b1, 1'b0, 8'h00);
			chk("slot", 16'(10'h001 << i), {6'h00, pulse});
		end
		put(1'b0, 1'b0, 8'h07);
		put(1'b1, 1'b0, 8'h00);
		chk("slot", 16'h0000, {6'h00, pulse});
		put(1'b0, 1'b0, 8'h0F);
		put(1'b1, 1'b0, 8'h00);
		chk("slot", 16'h0000, {ivalid, 5'h00, pulse});
		@(posedge sys_clk);
		pix <= 8'h5A;
		put(1'b0, 1'b0, 8'h04);
		put(1'b1, 1'b1, 8'h00);
		chk("rdata", 16'h035A, {6'h00, pxp, rvalid, rdata});
		put(1'b0, 1'b0, 8'h02);
		put(1'b1, 1'b1, 8'h00);
		chk("rdata", 16'h0100, {6'h00, pxp, rvalid, rdata});
		put(1'b0, 1'b0, 8'h01);
		put(1'b1, 1'b0, 8'h5B);
		chk("ctrl2", 16'h0006, {13'h0000, panel, opamp, ground});
		chk("ctrl2 rest", 16'h5B0F, {wdat, 4'h0, rmw, inc, ben, bact});
		put(1'b0, 1'b0, 8'h00);
		put(1'b1, 1'b0, 8'h30);
		chk("standby", 16'h0009, {12'h000, boost, panel, opamp, ground});
		chk("blink", 16'h0002, {14'h0000, ben, bact});
		@(posedge sys_clk);
		clk_en <= 1'b0;
		put(1'b0, 1'b0, 8'h03);
		chk("frozen", 16'h0000, {12'h000, idx});
		@(posedge sys_clk);
		clk_en <= 1'b1;
		put(1'b0, 1'b0, 8'h03);
		chk("index", 16'h0003, {12'h000, idx});
		// Mid-run reset must bring back the power-up state
		@(posedge sys_clk);
		rst_n <= 1'b0;
		@(posedge sys_clk);
		rst_n <= 1'b1;
		@(negedge sys_clk);
		chk("reset index", 16'h0010, {11'h000, ivalid, idx});
		chk("reset ctrl1", rows[0].e, ctl1());
		chk("reset panel", 16'h0001, {13'h0000, panel, opamp, ground});
		summarize();
	end
endmodule
`default_nettype wire
